// file: hw/mcp_defines.svh
`ifndef MCP_DEFINES_SVH
`define MCP_DEFINES_SVH

// ==========================================================
// Extension header layout
`define MCP_EF_BIT          7
`define MCP_TYPE_W          7
`define MCP_TYPE_SINGLE     7'h04
`define MCP_TYPE_MULTI      7'h05
`define MCP_LEN_SINGLE      8'h01
`define MCP_LEN_MULTI_MIN   8'h02
`define MCP_HDR_BYTES       10'h002

// ==========================================================
// Parameter set layout
`define MCP_SET_BITS        28
`define MCP_MASK_W          12
`define MCP_SCALE_W         15
`define MCP_EXP_W           4
`define MCP_MANT_W          11
`define MCP_FRAC_W          26
`define MCP_SHIFT_W         16
`define MCP_IQW_W           4
`define MCP_MASK_ALL        12'hfff

// ==========================================================
// Section types that may carry the extensions
`define MCP_SECT_W          4
`define MCP_SECT_A          4'h1
`define MCP_SECT_B          4'h3
`define MCP_SECT_C          4'h5

// ==========================================================
// Register map
`define MCP_ADDR_W          8
`define MCP_REG_CTRL        8'h00
`define MCP_REG_STATUS      8'h04
`define MCP_REG_EXT_CNT     8'h08
`define MCP_REG_ERR_CNT     8'h0c
`define MCP_REG_SINGLE      8'h10
`define MCP_REG_IQW         8'h14
`define MCP_CTRL_EN_BIT     0
`define MCP_CTRL_CLR_BIT    1
`define MCP_CTRL_RST        1'h1
`define MCP_IQW_RST         4'h4
`define MCP_MAX_WORDS       16

`endif

// file: hw/mcp_pkg.sv
`include "mcp_defines.svh"

package mcp_pkg;

    typedef enum logic [1:0] {
        MCP_IDLE    = 2'h0,
        MCP_COLLECT = 2'h1,
        MCP_CHECK   = 2'h3,
        MCP_EMIT    = 2'h2
    } mcp_state_t;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        logic [7:0] data;
    } mcp_byte_t;

    typedef struct packed {
        logic [`MCP_ADDR_W-1:0] addr;
        logic [31:0]            wdata;
        logic                   wr;
        logic                   rd;
    } mcp_reg_req_t;

    typedef struct packed {
        logic                    valid;
        logic                    last;
        logic                    extension_follows_flag;
        logic [`MCP_TYPE_W-1:0]  extension_type_code;
        logic [7:0]              index;
        logic [`MCP_MASK_W-1:0]  re_scale_select_mask;
        logic                    shift_flag;
        logic [`MCP_SCALE_W-1:0] set_scale_value;
        logic [`MCP_EXP_W-1:0]   exponent;
        logic [`MCP_MANT_W-1:0]  mantissa;
        logic [`MCP_FRAC_W-1:0]  scale_frac;
        logic [`MCP_SHIFT_W-1:0] shift_frac;
    } mcp_set_t;

    typedef struct packed {
        mcp_state_t              state;
        logic [7:0]              byte_cnt;
        logic                    drop;
        logic                    foreign;
        logic                    ef;
        logic [`MCP_TYPE_W-1:0]  ext_type;
        logic [7:0]              len_words;
        logic [7:0]              set_total;
        logic [7:0]              emit_idx;
        logic                    ctrl_en;
        logic [`MCP_IQW_W-1:0]   iq_width;
        logic [15:0]             ext_cnt;
        logic [15:0]             err_cnt;
        logic [7:0]              last_sets;
        logic [15:0]             single_last;
        logic                    in_ready;
        mcp_set_t                set_out;
        logic [31:0]             rdata;
    } mcp_core_t;

endpackage

// file: hw/mcp_set_extract.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcp_defines.svh"

module mcp_set_extract (
    input  wire logic [31:0]             word,
    input  wire logic                    odd,
    output logic      [`MCP_MASK_W-1:0]  mask,
    output logic                         csf,
    output logic      [`MCP_SCALE_W-1:0] scale
);
    logic [`MCP_SET_BITS-1:0] raw;

    // Odd sets begin in the low nibble of their first byte
    always_comb begin
        raw   = odd ? word[27:0] : word[31:4];
        mask  = raw[27:16];
        csf   = raw[15];
        scale = raw[14:0];
    end
endmodule

`default_nettype wire

// file: hw/mcp_scale_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcp_defines.svh"

module mcp_scale_decode (
    input  wire logic [`MCP_SCALE_W-1:0] scale,
    input  wire logic                    csf,
    input  wire logic [`MCP_IQW_W-1:0]   iq_sample_bit_width,
    output logic      [`MCP_EXP_W-1:0]   exponent,
    output logic      [`MCP_MANT_W-1:0]  mantissa,
    output logic      [`MCP_FRAC_W-1:0]  scale_frac,
    output logic      [`MCP_SHIFT_W-1:0] shift_frac
);
    localparam logic [`MCP_SHIFT_W-1:0] HALF = 16'h8000;

    always_comb begin
        exponent   = scale[14:11];
        mantissa   = scale[10:0];
        // Mantissa weight 2^-11 sits at bit 15 of the 26-bit fraction
        scale_frac = {mantissa, 15'h0000} >> exponent;
        // Shift of 2^-width; a width of zero is meaningless and yields no shift
        if (csf && iq_sample_bit_width != 4'h0) begin
            shift_frac = HALF >> (iq_sample_bit_width - 4'h1);
        end else begin
            shift_frac = 16'h0000;
        end
    end
endmodule

`default_nettype wire

// file: hw/mcp_param_ext_parser.sv
// Overview of operation
// - Both extensions are taken only inside sections of type 1, 3 or 5.
// - The single-set extension has type 4, length 1, flag atop octet 2 and scale in octets 2-3.
// - A set shift flag of 1 means the shift value is added to I and Q on decompression.
// - The shift value is two to the minus sample bit width.
// - The 15-bit scale splits into a 4-bit exponent and an 11-bit fractional mantissa.
// - The decoded scale runs from 0 to just under one and applies to unshifted points.
// - A one-set multi extension has type 5, length 2, mask, flag, scale, then zero padding.
// - Multi sets are packed back to back in 28 bits each, then padded to a word boundary.
// - A two-set multi extension has length 3 with the second set starting mid-octet 5.
// - Any number of sets that the length admits is parsed, for lengths up to MAX_WORDS words; longer ones are rejected.
// - When the payload is an exact multiple of 28 bits, a zero last set is dropped.
// - A length of four words decodes as three or four sets.
// - Each mask bit selects one resource element, the top bit the lowest frequency.
// - Per-set scale values decode in the same exponent and mantissa format.
`timescale 1ns/1ps
`default_nettype none
`include "mcp_defines.svh"

module mcp_param_ext_parser #(
    parameter int MAX_WORDS = `MCP_MAX_WORDS
) (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire mcp_pkg::mcp_byte_t       byte_in,
    input  wire logic [`MCP_SECT_W-1:0]   section_type,
    output logic                          in_ready,
    output mcp_pkg::mcp_set_t             set_out,
    input  wire mcp_pkg::mcp_reg_req_t    reg_req,
    output logic [31:0]                   reg_rdata
);
    import mcp_pkg::*;

    localparam int MAX_BYTES = 4 * MAX_WORDS;

    // ==========================================================
    // Parameter checks
    generate
        if (MAX_WORDS < 4 || MAX_WORDS > 63) begin : g_bad_words
            $error("MAX_WORDS must lie between 4 and 63");
        end
    endgenerate

    // ==========================================================
    // Helpers
    function automatic logic sect_ok(input logic [`MCP_SECT_W-1:0] st);
        return st == `MCP_SECT_A || st == `MCP_SECT_B || st == `MCP_SECT_C;
    endfunction

    // First payload byte of set k: header plus floor(3.5 * k)
    function automatic logic [9:0] set_byte_off(input logic [7:0] k);
        logic [10:0] seven_k;
        seven_k = {k, 3'b000} - {3'b000, k};
        return seven_k[10:1] + `MCP_HDR_BYTES;
    endfunction

    logic [7:0] buf_mem [MAX_BYTES];

    // Reads past the buffer return zero rather than wrapping
    function automatic logic [7:0] rd_byte(input logic [9:0] idx);
        if (idx < 10'(MAX_BYTES)) begin
            return buf_mem[idx[$clog2(MAX_BYTES)-1:0]];
        end
        return 8'h00;
    endfunction

    mcp_core_t q;
    mcp_core_t n;

    // ==========================================================
    // Set fetch and decode
    logic [12:0]             payload_bits;
    logic [7:0]              set_max;
    logic                    exact_fit;
    logic [7:0]              fetch_k;
    logic [9:0]              fetch_off;
    logic [31:0]             fetch_word;
    logic [`MCP_MASK_W-1:0]  ex_mask;
    logic                    ex_csf;
    logic [`MCP_SCALE_W-1:0] ex_scale;
    logic [`MCP_MASK_W-1:0]  sel_mask;
    logic                    sel_csf;
    logic [`MCP_SCALE_W-1:0] sel_scale;
    logic [`MCP_EXP_W-1:0]   dec_exp;
    logic [`MCP_MANT_W-1:0]  dec_mant;
    logic [`MCP_FRAC_W-1:0]  dec_frac;
    logic [`MCP_SHIFT_W-1:0] dec_shift;
    logic                    byte_take;

    always_comb begin
        // Length counts whole words including the two header bytes
        payload_bits = {q.len_words, 5'b00000} - 13'h0010;
        set_max      = 8'(payload_bits / 13'(`MCP_SET_BITS));
        exact_fit    = (13'(set_max) * 13'(`MCP_SET_BITS) == payload_bits);
        fetch_k      = (q.state == MCP_CHECK) ? set_max - 8'h01 : q.emit_idx;
        fetch_off    = set_byte_off(fetch_k);
        fetch_word   = {rd_byte(fetch_off), rd_byte(fetch_off + 10'h001),
                        rd_byte(fetch_off + 10'h002), rd_byte(fetch_off + 10'h003)};
        byte_take    = byte_in.valid && q.in_ready;
    end

    mcp_set_extract u_extract (
        .word  (fetch_word),
        .odd   (fetch_k[0]),
        .mask  (ex_mask),
        .csf   (ex_csf),
        .scale (ex_scale)
    );

    always_comb begin
        if (q.ext_type == `MCP_TYPE_SINGLE) begin
            // Single set covers every element of the block
            sel_mask  = `MCP_MASK_ALL;
            sel_csf   = fetch_word[31];
            sel_scale = fetch_word[30:16];
        end else begin
            sel_mask  = ex_mask;
            sel_csf   = ex_csf;
            sel_scale = ex_scale;
        end
    end

    mcp_scale_decode u_decode (
        .scale               (sel_scale),
        .csf                 (sel_csf),
        .iq_sample_bit_width (q.iq_width),
        .exponent            (dec_exp),
        .mantissa            (dec_mant),
        .scale_frac          (dec_frac),
        .shift_frac          (dec_shift)
    );

    // ==========================================================
    // Extension byte buffer
    always_ff @(posedge ref_clk) begin
        if (byte_take && q.byte_cnt < 8'(MAX_BYTES) &&
            (q.state == MCP_COLLECT || byte_in.first)) begin
            buf_mem[q.byte_cnt[$clog2(MAX_BYTES)-1:0]] <= byte_in.data;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic [9:0] total_bytes;
        logic       len_ok;
        total_bytes = 10'h000;
        len_ok      = 1'b0;
        n           = q;
        n.set_out.valid = 1'b0;
        n.set_out.last  = 1'b0;
        n.rdata         = 32'h0000_0000;

        // Register port; unmapped reads return zero
        if (reg_req.wr) begin
            case (reg_req.addr)
                `MCP_REG_CTRL: begin
                    n.ctrl_en = reg_req.wdata[`MCP_CTRL_EN_BIT];
                    if (reg_req.wdata[`MCP_CTRL_CLR_BIT]) begin
                        n.ext_cnt = 16'h0000;
                        n.err_cnt = 16'h0000;
                    end
                end
                `MCP_REG_IQW: n.iq_width = reg_req.wdata[`MCP_IQW_W-1:0];
                default: ;
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                `MCP_REG_CTRL:    n.rdata = {31'h0, q.ctrl_en};
                `MCP_REG_STATUS:  n.rdata = {20'h0, q.state, q.state != MCP_IDLE,
                                             q.in_ready, q.last_sets};
                `MCP_REG_EXT_CNT: n.rdata = {16'h0, q.ext_cnt};
                `MCP_REG_ERR_CNT: n.rdata = {16'h0, q.err_cnt};
                `MCP_REG_SINGLE:  n.rdata = {16'h0, q.single_last};
                `MCP_REG_IQW:     n.rdata = {28'h0, q.iq_width};
                default:          n.rdata = 32'h0000_0000;
            endcase
        end

        case (q.state)
            MCP_IDLE: begin
                n.in_ready = 1'b1;
                if (byte_take && byte_in.first) begin
                    n.ef       = byte_in.data[`MCP_EF_BIT];
                    n.ext_type = byte_in.data[`MCP_TYPE_W-1:0];
                    n.foreign  = byte_in.data[`MCP_TYPE_W-1:0] != `MCP_TYPE_SINGLE &&
                                 byte_in.data[`MCP_TYPE_W-1:0] != `MCP_TYPE_MULTI;
                    n.drop     = !q.ctrl_en || !sect_ok(section_type);
                    n.byte_cnt = 8'h01;
                    if (byte_in.last) begin
                        if (!n.foreign) begin
                            n.err_cnt = q.err_cnt + 16'h0001;
                        end
                    end else begin
                        n.state = MCP_COLLECT;
                    end
                end
            end
            MCP_COLLECT: begin
                if (byte_take) begin
                    if (q.byte_cnt == 8'h01) begin
                        n.len_words = byte_in.data;
                    end
                    if (q.byte_cnt != 8'hff) begin
                        n.byte_cnt = q.byte_cnt + 8'h01;
                    end
                    if (byte_in.last) begin
                        total_bytes = {2'b00, q.byte_cnt} + 10'h001;
                        if (q.ext_type == `MCP_TYPE_SINGLE) begin
                            len_ok = q.len_words == `MCP_LEN_SINGLE;
                        end else begin
                            len_ok = q.len_words >= `MCP_LEN_MULTI_MIN &&
                                     q.len_words <= 8'(MAX_WORDS);
                        end
                        len_ok = len_ok && total_bytes == {q.len_words, 2'b00};
                        if (!q.foreign && !q.drop && len_ok) begin
                            n.state    = MCP_CHECK;
                            n.in_ready = 1'b0;
                        end else begin
                            n.state = MCP_IDLE;
                            if (!q.foreign) begin
                                n.err_cnt = q.err_cnt + 16'h0001;
                            end
                        end
                    end
                end
            end
            MCP_CHECK: begin
                // Fetch is aimed at the candidate last set this cycle
                if (q.ext_type == `MCP_TYPE_SINGLE) begin
                    n.set_total = 8'h01;
                end else if (exact_fit && {ex_mask, ex_csf, ex_scale} == 28'h0) begin
                    n.set_total = set_max - 8'h01;
                end else begin
                    n.set_total = set_max;
                end
                n.emit_idx = 8'h00;
                n.state    = MCP_EMIT;
            end
            MCP_EMIT: begin
                // Only sets below set_total are read, so padding is never looked at
                n.set_out.valid                  = 1'b1;
                n.set_out.last                   = q.emit_idx == q.set_total - 8'h01;
                n.set_out.extension_follows_flag = q.ef;
                n.set_out.extension_type_code    = q.ext_type;
                n.set_out.index                  = q.emit_idx;
                n.set_out.re_scale_select_mask   = sel_mask;
                n.set_out.shift_flag             = sel_csf;
                n.set_out.set_scale_value        = sel_scale;
                n.set_out.exponent               = dec_exp;
                n.set_out.mantissa               = dec_mant;
                n.set_out.scale_frac             = dec_frac;
                n.set_out.shift_frac             = dec_shift;
                n.emit_idx                       = q.emit_idx + 8'h01;
                if (n.set_out.last) begin
                    n.state     = MCP_IDLE;
                    n.last_sets = q.set_total;
                    n.ext_cnt   = q.ext_cnt + 16'h0001;
                    if (q.ext_type == `MCP_TYPE_SINGLE) begin
                        n.single_last = {sel_csf, sel_scale};
                    end
                end
            end
            default: begin
                n.state    = MCP_IDLE;
                n.in_ready = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q          <= '0;
            q.state    <= MCP_IDLE;
            q.ctrl_en  <= `MCP_CTRL_RST;
            q.iq_width <= `MCP_IQW_RST;
            q.in_ready <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // Set masks are trusted as sent; overlaps pass through unchecked
    always_comb begin
        in_ready  = q.in_ready;
        set_out   = q.set_out;
        reg_rdata = q.rdata;
    end
endmodule

`default_nettype wire

// file: verification/mcp_du_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Sender of extension bytes, holds each byte until accepted
module mcp_du_model (
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    input  wire logic          in_ready,
    input  wire logic          slow,
    output mcp_pkg::mcp_byte_t byte_out
);
    import mcp_pkg::*;
    logic [9:0] q[$];
    logic       gap_r;

    task automatic push(input logic [9:0] b);
        q.push_back(b);
    endtask

    // Released data toggles each idle cycle between the inverse of the last byte and the byte itself
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_out <= '0;
            gap_r <= 1'b0;
        end else if (!byte_out.valid || in_ready) begin
            gap_r <= ~gap_r;
            if (q.size() != 0 && !(slow && gap_r)) begin
                byte_out <= {1'b1, q.pop_front()};
            end else begin
                byte_out.valid <= 1'b0;
                byte_out.first <= 1'b0;
                byte_out.last <= 1'b0;
                byte_out.data <= ~byte_out.data;
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/mcp_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcp_defines.svh"

module mcp_chk (
    input wire logic                   ref_clk,
    input wire logic                   sys_rst,
    input wire mcp_pkg::mcp_byte_t     byte_in,
    input wire logic [`MCP_SECT_W-1:0] section_type,
    input wire logic                   in_ready,
    input wire mcp_pkg::mcp_set_t      set_out,
    input wire mcp_pkg::mcp_reg_req_t  reg_req,
    input wire logic [31:0]            reg_rdata
);
    import mcp_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Set emission
    chk_ready_low: assert property (set_out.valid |-> !in_ready)
        else $error("in_ready high during set emission");
    chk_ready_back: assert property (set_out.valid && set_out.last |=> in_ready && !set_out.valid)
        else $error("in_ready not back after last set");
    chk_index_step: assert property (set_out.valid && !set_out.last |=>
        set_out.valid && set_out.index == $past(set_out.index) + 8'h1)
        else $error("set index did not advance by one");
    chk_first_index: assert property ($rose(set_out.valid) |-> set_out.index == 8'h0)
        else $error("first set index not zero");
    chk_type_known: assert property (set_out.valid |-> set_out.extension_type_code inside {7'h04, 7'h05})
        else $error("set from unknown extension type");
    chk_single_set: assert property (set_out.valid && set_out.extension_type_code == 7'h04 |->
        set_out.last && set_out.index == 8'h0 && set_out.re_scale_select_mask == 12'hfff)
        else $error("single-set extension emitted wrong set");

    // ==========================================================
    // Scale and shift decoding, and idle read data
    chk_exp_split: assert property (set_out.valid |->
        {set_out.exponent, set_out.mantissa} == set_out.set_scale_value)
        else $error("exponent or mantissa split wrong");
    chk_scale_frac: assert property (set_out.valid |->
        set_out.scale_frac == (26'(set_out.mantissa) << (15 - set_out.exponent)))
        else $error("scale fraction wrong");
    chk_shift_off: assert property (set_out.valid && !set_out.shift_flag |-> set_out.shift_frac == 16'h0)
        else $error("shift present without flag");
    chk_shift_pow: assert property (set_out.valid && set_out.shift_frac != 16'h0 |-> $onehot(set_out.shift_frac))
        else $error("shift value not a power of two");
    chk_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 32'h0)
        else $error("read data without a read");
endmodule

bind mcp_param_ext_parser mcp_chk i_mcp_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .byte_in(byte_in), .section_type(section_type),
    .in_ready(in_ready), .set_out(set_out), .reg_req(reg_req), .reg_rdata(reg_rdata));
`default_nettype wire

// file: verification/mcp_param_ext_parser_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcp_defines.svh"

module mcp_param_ext_parser_bench;
    import mcp_pkg::*;
    logic                   ref_clk = 1'b0;
    logic                   sys_rst = 1'b1;
    logic                   slow = 1'b0;
    logic [`MCP_SECT_W-1:0] section_type = 4'h1;
    mcp_reg_req_t           reg_req = '0;
    mcp_byte_t              byte_in;
    logic                   in_ready;
    mcp_set_t               set_out;
    logic [31:0]            reg_rdata;
    mcp_set_t               got[$];
    logic [27:0]            sets[8];
    int                     mismatches = 0;
    int                     compares = 0;

    always #12.5 ref_clk = ~ref_clk;

    mcp_param_ext_parser i_mcp_param_ext_parser (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .byte_in(byte_in), .section_type(section_type),
        .in_ready(in_ready), .set_out(set_out), .reg_req(reg_req), .reg_rdata(reg_rdata));
    mcp_du_model i_mcp_du_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .in_ready(in_ready),
        .slow(slow), .byte_out(byte_in));

    always @(posedge ref_clk) begin
        if (set_out.valid === 1'b1) got.push_back(set_out);
    end

    // ==========================================================
    // Verdict and comparisons
    task automatic results();
        if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_set(input mcp_set_t g, input mcp_set_t e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // ==========================================================
    // Register bus
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk) reg_req.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk) reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk) reg_req.rd <= 1'b0;
        #1 chk32(reg_rdata, e);
    endtask

    // ==========================================================
    // Extension building and set checking
    function automatic mcp_set_t exp_set(input logic [6:0] t, input logic ef, input int i,
                                         input int n, input int w);
        mcp_set_t s;
        s = '0;
        s.valid = 1'b1;
        s.last = (i == n - 1);
        s.extension_follows_flag = ef;
        s.extension_type_code = t;
        s.index = 8'(i);
        {s.re_scale_select_mask, s.shift_flag, s.set_scale_value} = sets[i];
        {s.exponent, s.mantissa} = sets[i][14:0];
        s.scale_frac = 26'(sets[i][10:0]) << (15 - sets[i][14:11]);
        s.shift_frac = (sets[i][15] && w != 0) ? 16'h1 << (16 - w) : 16'h0;
        return s;
    endfunction

    // Masks partition the block so every element is covered exactly once
    task automatic build_sets(input int n);
        for (int i = 0; i < n; i++)
            sets[i] = {(i == n - 1) ? 12'hfff >> i : 12'h800 >> i, 1'(i), 15'h0a00 + 15'(i * 37)};
    endtask

    task automatic send(input logic [3:0] sect, input logic [7:0] hdr, input int len,
                        input int n, input logic padv);
        logic [511:0] p;
        int           nb;
        p = '0;
        nb = len * 32 - 16;
        for (int i = 0; i < n; i++) p = (p << 28) | 512'(sets[i]);
        p = p << (nb - n * 28);
        if (padv) p = p | ((512'(1) << (nb - n * 28)) - 1);
        if (hdr[6:0] == 7'h04) p = 512'(sets[0][15:0]);
        @(posedge ref_clk) section_type <= sect;
        i_mcp_du_model.push({2'b10, hdr});
        i_mcp_du_model.push({2'b00, 8'(len)});
        for (int k = 0; k < nb / 8; k++) i_mcp_du_model.push({1'b0, k == nb / 8 - 1, p[nb - 1 - 8 * k -: 8]});
        do begin
            @(posedge ref_clk);
            #1;
        end while (i_mcp_du_model.q.size() != 0 || byte_in.valid !== 1'b0 || in_ready !== 1'b1);
    endtask

    task automatic check_sets(input logic [6:0] t, input logic ef, input int n, input int w);
        chk32(32'(got.size()), 32'(n));
        for (int i = 0; i < n && i < got.size(); i++) chk_set(got[i], exp_set(t, ef, i, n, w));
        got.delete();
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        reg_rd(8'h00, 32'h1);
        reg_rd(8'h14, 32'h4);
        reg_wr(8'h40, 32'hffff_ffff);
        reg_rd(8'h40, 32'h0);
        reg_rd(8'h08, 32'h0);
    endtask

    task automatic t_single();
        sets[0] = {12'hfff, 1'b1, 15'h0534};
        send(4'h1, 8'h04, 1, 0, 1'b0);
        check_sets(7'h04, 1'b0, 1, 4);
        reg_rd(8'h10, 32'h8534);
        sets[0] = {12'hfff, 1'b0, 15'h7fff};
        send(4'h3, 8'h84, 1, 0, 1'b0);
        check_sets(7'h04, 1'b1, 1, 4);
    endtask

    task automatic t_multi();
        @(posedge ref_clk) slow <= 1'b1;
        sets[0] = {12'habc, 1'b1, 15'h1234};
        sets[1] = {12'h543, 1'b0, 15'h7fff};
        send(4'h5, 8'h05, 3, 2, 1'b0);
        check_sets(7'h05, 1'b0, 2, 4);
        send(4'h1, 8'h05, 2, 1, 1'b1);
        check_sets(7'h05, 1'b0, 1, 4);
        @(posedge ref_clk) slow <= 1'b0;
    endtask

    task automatic t_count();
        build_sets(3);
        sets[3] = 28'h0;
        send(4'h1, 8'h05, 4, 4, 1'b0);
        check_sets(7'h05, 1'b0, 3, 4);
        build_sets(4);
        send(4'h3, 8'h05, 4, 4, 1'b0);
        check_sets(7'h05, 1'b0, 4, 4);
        build_sets(5);
        send(4'h5, 8'h05, 5, 5, 1'b0);
        check_sets(7'h05, 1'b0, 5, 4);
        reg_rd(8'h04, 32'h105);
    endtask

    task automatic t_shift();
        for (int w = 1; w <= 5; w++) begin
            reg_wr(8'h14, 32'(w));
            sets[0] = {12'hfff, 1'b1, 15'h7abc};
            send(4'h1, 8'h04, 1, 0, 1'b0);
            check_sets(7'h04, 1'b0, 1, w);
        end
    endtask

    task automatic t_reject();
        reg_wr(8'h00, 32'h3);
        sets[0] = {12'hfff, 1'b1, 15'h0001};
        send(4'h2, 8'h04, 1, 0, 1'b0);
        check_sets(7'h04, 1'b0, 0, 4);
        send(4'h1, 8'h04, 2, 0, 1'b0);
        check_sets(7'h04, 1'b0, 0, 4);
        reg_wr(8'h00, 32'h0);
        send(4'h1, 8'h04, 1, 0, 1'b0);
        check_sets(7'h04, 1'b0, 0, 4);
        reg_wr(8'h00, 32'h1);
        reg_rd(8'h0c, 32'h3);
        reg_rd(8'h08, 32'h0);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_single();
        t_multi();
        t_count();
        t_reject();
        t_shift();
        results();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (8000) @(posedge ref_clk);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
